//--- hw/adcc_pkg.sv
// package: register map, field layout and types of the converter control
package adcc_pkg;

    // ****************************************************************
    // register map
    // ****************************************************************
    localparam logic [31:0] ADCC_CTRL_OFFSET   = 32'h0000_0000;
    localparam logic [31:0] ADCC_STATUS_OFFSET = 32'h0000_0004;
    localparam logic [7:0]  ADCC_CTRL_RESET    = 8'h00;

    // ****************************************************************
    // control field positions
    // ****************************************************************
    localparam int ADCC_FORMAT_BIT = 7;
    localparam int ADCC_VREF_BIT   = 6;
    localparam int ADCC_CHAN_LSB   = 2;
    localparam int ADCC_GO_BIT     = 1;
    localparam int ADCC_ENABLE_BIT = 0;

    // ****************************************************************
    // channel codes
    // ****************************************************************
    localparam int          ADCC_EXT_CHANNELS = 12;
    localparam logic [3:0]  ADCC_CHAN_LAST    = 4'h000B;
    localparam logic [3:0]  ADCC_CHAN_CMPREF  = 4'h000C;
    localparam logic [3:0]  ADCC_CHAN_FIXREF  = 4'h000D;

    // ****************************************************************
    // status field positions
    // ****************************************************************
    localparam int ADCC_STAT_BUSY_BIT = 0;
    localparam int ADCC_STAT_RSVD_BIT = 1;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef struct packed {
        logic       result_format_select;
        logic       reference_source_select;
        logic [3:0] input_channel_select;
        logic       conversion_busy;
        logic       converter_enable;
    } adcc_ctrl_t;

    typedef struct packed {
        logic [ADCC_EXT_CHANNELS-1:0] ext_select;
        logic                         cmp_ref_select;
        logic                         fixed_ref_select;
        logic                         right_justify;
        logic                         ext_vref_select;
        logic                         enable;
    } adcc_analog_t;

endpackage

//--- hw/adcc_top.sv
// module: converter control register with an AHB-Lite slave port
//
// Operation
// - bit 7 set gives right justified result, cleared gives left justified.
// - channel codes 0 to 11 route external input N to the converter.
// - code 12 routes comparator reference, code 13 the 0.6V reference.
// - writing one to bit 1 starts a new conversion (here only if bit 0 is set and no conversion is running).
// - hardware clears bit 1 when the running conversion finishes.
// - bit 1 reads one while converting, zero when done or idle.
// - bit 0 enables converter; cleared holds conversion logic idle.
//
// Decided for this implementation: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps

module adcc_top
(
    // clock and reset
    input  wire logic                     CLOCK,
    input  wire logic                     RSTN,
    // ahb-lite slave
    input  wire logic                     HSEL,
    input  wire logic [31:0]              HADDR,
    input  wire logic [1:0]               HTRANS,
    input  wire logic                     HWRITE,
    input  wire logic [2:0]               HSIZE,
    input  wire logic [31:0]              HWDATA,
    input  wire logic                     HREADY,
    output logic      [31:0]              HRDATA,
    output logic                          HREADYOUT,
    output logic                          HRESP,
    // analog front end
    input  wire logic                     CONV_DONE,
    output logic                          CONV_START,
    output adcc_pkg::adcc_analog_t        ANALOG
);

    import adcc_pkg::*;

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [ADCC_EXT_CHANNELS-1:0] ext_decode
    (
        input logic [3:0] code
    );
        logic [ADCC_EXT_CHANNELS-1:0] sel;
        sel = '0;
        if (code <= ADCC_CHAN_LAST)
        begin
            sel[code] = 1'b1;
        end
        return sel;
    endfunction

    function automatic logic [7:0] ctrl_pack
    (
        input adcc_ctrl_t c
    );
        return {c.result_format_select, c.reference_source_select,
                c.input_channel_select, c.conversion_busy,
                c.converter_enable};
    endfunction

    function automatic logic reg_hit
    (
        input logic [31:0] addr,
        input logic [31:0] offset
    );
        return addr == offset;
    endfunction

    // ****************************************************************
    // declarations
    // ****************************************************************
    adcc_ctrl_t    ctrl_q;
    adcc_ctrl_t    ctrl_d;
    adcc_analog_t  analog_q;
    adcc_analog_t  analog_d;
    logic          wr_pend_q;
    logic [31:0]   wr_addr_q;
    logic [31:0]   rdata_q;
    logic [31:0]   rdata_d;
    logic          start_q;
    logic          done_s1_q;
    logic          done_s2_q;
    logic          done_s3_q;
    logic          addr_phase;
    logic          wr_format;
    logic          wr_vref;
    logic [3:0]    wr_chan;
    logic          wr_go;
    logic          wr_enable;
    logic          rd_ctrl_hit;
    logic          rd_status_hit;
    logic          abort_now;
    logic          ctrl_write;
    logic          go_write;
    logic          go_clear_write;
    logic          done_rise;
    logic          new_enable;
    logic          start_now;
    logic          finish_now;
    logic          next_busy;
    logic          rsvd_code;
    logic [31:0]   ctrl_word;
    logic [31:0]   status_word;

    // ****************************************************************
    // bus decode
    // ****************************************************************
    assign addr_phase = HSEL & HREADY & HTRANS[1];
    assign ctrl_write = wr_pend_q & reg_hit(wr_addr_q, ADCC_CTRL_OFFSET);
    assign rd_ctrl_hit = addr_phase & ~HWRITE
                       & reg_hit(HADDR, ADCC_CTRL_OFFSET);
    assign rd_status_hit = addr_phase & ~HWRITE
                         & reg_hit(HADDR, ADCC_STATUS_OFFSET);

    // ****************************************************************
    // write data fields
    // ****************************************************************
    assign wr_format = HWDATA[ADCC_FORMAT_BIT];
    assign wr_vref = HWDATA[ADCC_VREF_BIT];
    assign wr_chan = HWDATA[ADCC_CHAN_LSB +: 4];
    assign wr_go = HWDATA[ADCC_GO_BIT];
    assign wr_enable = HWDATA[ADCC_ENABLE_BIT];
    assign go_write = ctrl_write & wr_go;
    assign go_clear_write = ctrl_write & ~wr_go;

    // ****************************************************************
    // conversion sequencing
    // ****************************************************************
    assign done_rise = done_s2_q & ~done_s3_q;
    assign new_enable = ctrl_write ? wr_enable
                                   : ctrl_q.converter_enable;
    // start only when enabled and not already converting
    assign start_now = go_write & new_enable
                     & ~ctrl_q.conversion_busy;
    assign finish_now = ctrl_q.conversion_busy & done_rise;
    // clearing go or enable while busy drops the conversion
    assign abort_now = go_clear_write | ~new_enable;
    // a start needs idle and a finish needs busy, so the two never meet in one cycle
    assign next_busy = start_now
                     | (ctrl_q.conversion_busy & ~finish_now
                        & ~abort_now);

    always_comb
    begin
        ctrl_d = ctrl_q;
        if (ctrl_write)
        begin
            ctrl_d.result_format_select    = wr_format;
            ctrl_d.reference_source_select = wr_vref;
            ctrl_d.input_channel_select    = wr_chan;
            ctrl_d.converter_enable        = wr_enable;
        end
        ctrl_d.conversion_busy = next_busy;
    end

    // ****************************************************************
    // analog selection
    // ****************************************************************
    assign rsvd_code = ctrl_d.input_channel_select > ADCC_CHAN_FIXREF;

    always_comb
    begin
        analog_d.ext_select       =
            ext_decode(ctrl_d.input_channel_select);
        analog_d.cmp_ref_select   =
            ctrl_d.input_channel_select == ADCC_CHAN_CMPREF;
        analog_d.fixed_ref_select =
            ctrl_d.input_channel_select == ADCC_CHAN_FIXREF;
        analog_d.right_justify    = ctrl_d.result_format_select;
        analog_d.ext_vref_select  = ctrl_d.reference_source_select;
        analog_d.enable           = ctrl_d.converter_enable;
    end

    // ****************************************************************
    // read data
    // ****************************************************************
    assign ctrl_word = {24'h0000_00, ctrl_pack(ctrl_d)};
    assign status_word = {30'h0000_0000, rsvd_code, ctrl_d.conversion_busy};

    always_comb
    begin
        rdata_d = 32'h0000_0000;
        if (rd_ctrl_hit)
        begin
            rdata_d = ctrl_word;
        end
        else if (rd_status_hit)
        begin
            rdata_d = status_word;
        end
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    always_ff @(posedge CLOCK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            ctrl_q <= adcc_ctrl_t'(ADCC_CTRL_RESET);
        end
        else
        begin
            ctrl_q <= ctrl_d;
        end
    end

    always_ff @(posedge CLOCK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            wr_pend_q <= 1'b0;
        end
        else
        begin
            wr_pend_q <= addr_phase & HWRITE;
        end
    end

    always_ff @(posedge CLOCK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            wr_addr_q <= 32'h0000_0000;
        end
        else
        begin
            wr_addr_q <= HADDR;
        end
    end

    always_ff @(posedge CLOCK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            rdata_q <= 32'h0000_0000;
        end
        else
        begin
            rdata_q <= rdata_d;
        end
    end

    always_ff @(posedge CLOCK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            analog_q <= '0;
        end
        else
        begin
            analog_q <= analog_d;
        end
    end

    always_ff @(posedge CLOCK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            start_q <= 1'b0;
        end
        else
        begin
            start_q <= start_now;
        end
    end

    always_ff @(posedge CLOCK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            done_s1_q <= 1'b0;
            done_s2_q <= 1'b0;
        end
        else
        begin
            done_s1_q <= CONV_DONE;
            done_s2_q <= done_s1_q;
        end
    end

    // edge detect on the synchronised done
    always_ff @(posedge CLOCK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            done_s3_q <= 1'b0;
        end
        else
        begin
            done_s3_q <= done_s2_q;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign HRDATA = rdata_q;
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;
    assign CONV_START = start_q;
    assign ANALOG = analog_q;

endmodule

//--- bench/adcc_props.sv
// checker: concurrent properties of the converter control ports
`timescale 1ns/1ps
module adcc_props
(
    // bus and front end
    input wire logic                   CLOCK,
    input wire logic                   RSTN,
    input wire logic                   HSEL,
    input wire logic [31:0]            HADDR,
    input wire logic [1:0]             HTRANS,
    input wire logic                   HWRITE,
    input wire logic [31:0]            HWDATA,
    input wire logic                   HREADY,
    input wire logic                   CONV_START,
    input wire adcc_pkg::adcc_analog_t ANALOG
);
    import adcc_pkg::*;
    wire wr_ctrl = HSEL & HREADY & HTRANS[1] & HWRITE
                   & (HADDR == ADCC_CTRL_OFFSET);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RSTN);
    a_fmt_follow: assert property (
        wr_ctrl |=> ##1 ANALOG.right_justify == $past(HWDATA[7])
    ) else $error("format select mismatch");
    a_vref_follow: assert property (
        wr_ctrl |=> ##1 ANALOG.ext_vref_select == $past(HWDATA[6])
    ) else $error("reference select mismatch");
    a_enable_follow: assert property (
        wr_ctrl |=> ##1 ANALOG.enable == $past(HWDATA[0])
    ) else $error("enable mismatch");
    a_chan_ext: assert property (
        wr_ctrl |=> ##1 ANALOG.ext_select == (($past(HWDATA[5:2]) < 12)
            ? (12'h001 << $past(HWDATA[5:2])) : 12'h000)
    ) else $error("external channel mismatch");
    a_chan_ref: assert property (
        wr_ctrl |=> ##1 ANALOG.cmp_ref_select == ($past(HWDATA[5:2]) == 4'hC)
            && ANALOG.fixed_ref_select == ($past(HWDATA[5:2]) == 4'hD)
    ) else $error("reference channel mismatch");
    a_start_cause: assert property (
        CONV_START |-> $past(wr_ctrl, 2) && $past(HWDATA[1:0]) == 2'h3
    ) else $error("start without go write");
    a_start_single: assert property (
        CONV_START |=> !CONV_START
    ) else $error("start pulse too long");
    a_start_enabled: assert property (
        CONV_START |-> ANALOG.enable
    ) else $error("start while disabled");
endmodule
bind adcc_top adcc_props i_props (.CLOCK(CLOCK), .RSTN(RSTN), .HSEL(HSEL),
    .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA),
    .HREADY(HREADY), .CONV_START(CONV_START), .ANALOG(ANALOG));

//--- bench/tb_top.sv
// testbench: register and conversion sequences over the bus
`timescale 1ns/1ps
`define CHK(got, exp) \
    n_tests++; \
    if ((got) !== (exp)) \
    begin \
        n_mismatch++; \
        $display("Error at %0t: got %h, expected %h", $time, got, exp); \
    end
module tb_top;
    import adcc_pkg::*;
    logic         CLOCK, RSTN, HSEL, HWRITE, CONV_DONE;
    logic         HREADYOUT, HRESP, CONV_START;
    logic [1:0]   HTRANS;
    logic [2:0]   HSIZE;
    logic [31:0]  HADDR, HWDATA, HRDATA, rd, wd;
    adcc_analog_t ANALOG;
    int           n_mismatch, n_tests, n_start, cyc, s;
    adcc_top i_dut (.CLOCK(CLOCK), .RSTN(RSTN), .HSEL(HSEL), .HADDR(HADDR),
        .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
        .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
        .HRESP(HRESP), .CONV_DONE(CONV_DONE), .CONV_START(CONV_START),
        .ANALOG(ANALOG));
    initial
    begin
        CLOCK = 1'h0;
        forever #10 CLOCK = ~CLOCK;
    end
    always @(posedge CLOCK)
        if (CONV_START === 1'h1) n_start++;
    always @(posedge CLOCK)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            n_mismatch++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("tests %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic ahb(input logic w, input logic [31:0] a,
                       input logic [31:0] d);
        HTRANS <= 2'h2;
        HWRITE <= w;
        HADDR  <= a;
        @(posedge CLOCK);
        while (HREADYOUT !== 1'h1) @(posedge CLOCK);
        HTRANS <= 2'h0;
        HWDATA <= d;
        @(posedge CLOCK);
        while (HREADYOUT !== 1'h1) @(posedge CLOCK);
        rd = HRDATA;
        `CHK(HRESP, 1'h0)
    endtask
    initial
    begin
        {RSTN, HSEL, HWRITE, CONV_DONE, HTRANS, HADDR, HWDATA} = '0;
        HSIZE = 3'h2;
        repeat (20) @(posedge CLOCK);
        RSTN <= 1'h1;
        @(posedge CLOCK);
        HSEL <= 1'h1;
        `CHK(ANALOG, adcc_analog_t'(0))
        ahb(0, ADCC_CTRL_OFFSET, 0);
        `CHK(rd, 32'h0000_0000)
        for (int c = 0; c < 14; c++)
        begin
            wd = {24'h00_0000, c[0], c[1], c[3:0], 2'h1};
            ahb(1, ADCC_CTRL_OFFSET, wd);
            ahb(0, ADCC_CTRL_OFFSET, 0);
            `CHK(rd, wd)
            `CHK(ANALOG.ext_select, c < 12 ? 12'h001 << c : 12'h000)
            `CHK(ANALOG.cmp_ref_select, c == 12)
            `CHK(ANALOG.fixed_ref_select, c == 13)
            `CHK(ANALOG.right_justify, c[0])
            `CHK(ANALOG.ext_vref_select, c[1])
            `CHK(ANALOG.enable, 1'h1)
        end
        s = n_start;
        ahb(1, ADCC_CTRL_OFFSET, 32'h0000_0003);
        ahb(1, ADCC_CTRL_OFFSET, 32'h0000_0003);
        ahb(0, ADCC_STATUS_OFFSET, 0);
        `CHK(rd, 32'h0000_0001)
        `CHK(n_start, s + 1)
        CONV_DONE <= 1'h1;
        repeat (4) @(posedge CLOCK);
        CONV_DONE <= 1'h0;
        ahb(0, ADCC_CTRL_OFFSET, 0);
        `CHK(rd, 32'h0000_0001)
        ahb(1, ADCC_CTRL_OFFSET, 32'h0000_0002);
        ahb(0, ADCC_STATUS_OFFSET, 0);
        `CHK(rd, 32'h0000_0000)
        ahb(1, ADCC_CTRL_OFFSET, 32'h0000_0003);
        ahb(1, ADCC_CTRL_OFFSET, 32'h0000_0000);
        ahb(0, ADCC_STATUS_OFFSET, 0);
        `CHK(rd, 32'h0000_0000)
        `CHK(n_start, s + 2)
        ahb(1, ADCC_CTRL_OFFSET, 32'h0000_0003);
        ahb(1, ADCC_CTRL_OFFSET, 32'h0000_0001);
        ahb(0, ADCC_CTRL_OFFSET, 0);
        `CHK(rd, 32'h0000_0001)
        `CHK(n_start, s + 3)
        ahb(1, 32'h0000_0008, 32'h0000_00FF);
        ahb(0, 32'h0000_0008, 0);
        `CHK(rd, 32'h0000_0000)
        ahb(0, ADCC_CTRL_OFFSET, 0);
        `CHK(rd, 32'h0000_0001)
        print_verdict();
    end
endmodule
